//--- inc/rail_seq_pkg.sv
// shared constants and types for the rail sequencing / tuning block
package rail_seq_pkg;

  // ==========================================================
  // command codes and widths
  localparam logic [7:0]  CODE_LOOP_TUNING = 8'h00_DF;
  localparam logic [7:0]  CODE_RAIL_ORDER  = 8'h00_E0;
  localparam logic [7:0]  CODE_VOLT_FOLLOW = 8'h00_E1;
  localparam int          PAGE_W           = 1;
  localparam int          RAIL_ID_W        = 5;

  // ==========================================================
  // loop_tuning_config layout
  localparam int          TUNE_EN_BIT      = 24;
  localparam int          TUNE_RES_LSB     = 16;
  localparam int          TUNE_RES_MSB     = 23;
  localparam int          TUNE_GAIN_MSB    = 15;
  localparam logic [7:0]  TUNE_RES_MAX     = 8'h00_7F;
  localparam logic [31:0] TUNE_MASK        = 32'h01FF_FFFF;
  localparam logic        TUNE_EN_RESET    = 1'b1;
  // strap decode: gain = base + code * step, residual = base + code[4:0]
  localparam logic [15:0] STRAP_GAIN_BASE  = 16'h0064;
  localparam logic [15:0] STRAP_GAIN_STEP  = 16'h0008;
  localparam logic [7:0]  STRAP_RES_BASE   = 8'h00_28;
  localparam int          STRAP_SETTLE     = 2;

  // ==========================================================
  // rail_order_links layout
  localparam int          PREQ_EN_BIT      = 15;
  localparam int          PREQ_ID_LSB      = 8;
  localparam int          SEQL_EN_BIT      = 7;
  localparam int          SEQL_ID_LSB      = 0;
  localparam logic [15:0] ORDER_MASK       = 16'h9F9F;
  localparam logic [15:0] ORDER_RESET      = 16'h0000;

  // ==========================================================
  // voltage_follow_config layout
  localparam int          TRK_EN_BIT       = 7;
  localparam int          TRK_HALF_BIT     = 2;
  localparam int          TRK_LIMREF_BIT   = 1;
  localparam logic [7:0]  TRACK_MASK       = 8'h00_86;
  localparam logic [7:0]  TRACK_RESET      = 8'h00_00;

  // ==========================================================
  // timing
  localparam int          CLK_PERIOD_NS    = 10;
  localparam int          TOFF_DELAY_NS    = 2000;
  localparam int          TOFF_CYC = (TOFF_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ==========================================================
  // types
  typedef enum logic {EVT_RAIL_GOOD = 1'b0, EVT_RAIL_DOWN = 1'b1} evt_kind_t;

  typedef enum logic [2:0] {
    ST_OFF       = 3'b000,
    ST_WAIT_PREQ = 3'b001,
    ST_ON        = 3'b011,
    ST_WAIT_SEQL = 3'b010,
    ST_TOFF      = 3'b110,
    ST_RAMP      = 3'b111
  } rail_state_t;

endpackage : rail_seq_pkg

//--- inc/rail_seq_if.sv
// command port and sequencing event link between controller and device
`timescale 1ns/1ps
interface rail_seq_if;
  import rail_seq_pkg::*;

  // ==========================================================
  // paged command access
  logic                 cmd_valid;
  logic                 cmd_write;
  logic [7:0]           cmd_code;
  logic [PAGE_W-1:0]    cmd_page;
  logic [31:0]          cmd_wdata;
  logic                 rsp_valid;
  logic                 rsp_err;
  logic [31:0]          rsp_rdata;
  // ==========================================================
  // sequencing events, toward the device and from it
  logic                 dn_evt_valid;
  evt_kind_t            dn_evt_kind;
  logic [RAIL_ID_W-1:0] dn_evt_rail;
  logic                 up_evt_valid;
  evt_kind_t            up_evt_kind;
  logic [RAIL_ID_W-1:0] up_evt_rail;

  modport dev (
    input  cmd_valid, cmd_write, cmd_code, cmd_page, cmd_wdata,
    input  dn_evt_valid, dn_evt_kind, dn_evt_rail,
    output rsp_valid, rsp_err, rsp_rdata,
    output up_evt_valid, up_evt_kind, up_evt_rail
  );
  modport ctl (
    output cmd_valid, cmd_write, cmd_code, cmd_page, cmd_wdata,
    output dn_evt_valid, dn_evt_kind, dn_evt_rail,
    input  rsp_valid, rsp_err, rsp_rdata,
    input  up_evt_valid, up_evt_kind, up_evt_rail
  );
endinterface : rail_seq_if

//--- src/rail_seq_ctl.sv
// controller end: issues paged commands and broadcasts sequencing events
`timescale 1ns/1ps
module rail_seq_ctl (
  input  wire logic                                 i_ref_clk,
  input  wire logic                                 i_rstn,
  rail_seq_if.ctl                                   bus,
  input  wire logic                                 i_cmd_req,
  input  wire logic                                 i_cmd_write,
  input  wire logic [7:0]                           i_cmd_code,
  input  wire logic [rail_seq_pkg::PAGE_W-1:0]      i_cmd_page,
  input  wire logic [31:0]                          i_cmd_wdata,
  output logic                                      o_cmd_ready,
  output logic                                      o_rsp_valid,
  output logic                                      o_rsp_err,
  output logic [31:0]                               o_rsp_rdata,
  input  wire logic                                 i_evt_req,
  input  wire rail_seq_pkg::evt_kind_t              i_evt_kind,
  input  wire logic [rail_seq_pkg::RAIL_ID_W-1:0]   i_evt_rail,
  output logic                                      o_evt_valid,
  output rail_seq_pkg::evt_kind_t                   o_evt_kind,
  output logic [rail_seq_pkg::RAIL_ID_W-1:0]        o_evt_rail
);
  import rail_seq_pkg::*;

  logic busy_reg;

  // ==========================================================
  // one command outstanding; software keeps its own ranges
  assign o_cmd_ready = ~busy_reg;

  // command launch, held until the device answers
  always_ff @(posedge i_ref_clk or negedge i_rstn)
    if (!i_rstn)
    begin
      busy_reg      <= 1'b0;
      bus.cmd_valid <= 1'b0;
      bus.cmd_write <= 1'b0;
      bus.cmd_code  <= 8'h00_00;
      bus.cmd_page  <= '0;
      bus.cmd_wdata <= 32'h0000_0000;
    end
    else
    begin
      bus.cmd_valid <= i_cmd_req & ~busy_reg;
      if (i_cmd_req && !busy_reg)
      begin
        busy_reg      <= 1'b1;
        bus.cmd_write <= i_cmd_write;
        bus.cmd_code  <= i_cmd_code;
        bus.cmd_page  <= i_cmd_page;
        bus.cmd_wdata <= i_cmd_wdata;   // field layout per device map
      end
      else if (bus.rsp_valid)
        busy_reg <= 1'b0;
    end

  // answer captured for the user side
  always_ff @(posedge i_ref_clk or negedge i_rstn)
    if (!i_rstn)
    begin
      o_rsp_valid <= 1'b0;
      o_rsp_err   <= 1'b0;
      o_rsp_rdata <= 32'h0000_0000;
    end
    else
    begin
      o_rsp_valid <= bus.rsp_valid;
      if (bus.rsp_valid)
      begin
        o_rsp_err   <= bus.rsp_err;
        o_rsp_rdata <= bus.rsp_rdata;
      end
    end

  // ==========================================================
  // event relay in both directions, one cycle of latency each
  always_ff @(posedge i_ref_clk or negedge i_rstn)
    if (!i_rstn)
    begin
      bus.dn_evt_valid <= 1'b0;
      bus.dn_evt_kind  <= EVT_RAIL_GOOD;
      bus.dn_evt_rail  <= '0;
      o_evt_valid      <= 1'b0;
      o_evt_kind       <= EVT_RAIL_GOOD;
      o_evt_rail       <= '0;
    end
    else
    begin
      bus.dn_evt_valid <= i_evt_req;
      bus.dn_evt_kind  <= i_evt_kind;
      bus.dn_evt_rail  <= i_evt_rail;
      o_evt_valid      <= bus.up_evt_valid;
      o_evt_kind       <= bus.up_evt_kind;
      o_evt_rail       <= bus.up_evt_rail;
    end

endmodule : rail_seq_ctl

//--- src/rail_seq_dev.sv
// device end: tuning, rail ordering and tracking configuration per page
`timescale 1ns/1ps
module rail_seq_dev #(
  parameter int NUM_PAGES   = 2,
  parameter int TOFF_CYCLES = rail_seq_pkg::TOFF_CYC
) (
  input  wire logic                                        i_ref_clk,
  input  wire logic                                        i_rstn,
  rail_seq_if.dev                                          bus,
  input  wire logic [7:0]                                  i_tuning_strap_pin,
  input  wire logic [15:0]                                 i_order_strap,
  input  wire logic [15:0]                                 i_vin_meas,
  input  wire logic [NUM_PAGES-1:0][15:0]                  i_vout_cmd,
  input  wire logic [NUM_PAGES-1:0][rail_seq_pkg::RAIL_ID_W-1:0] i_rail_id,
  input  wire logic [NUM_PAGES-1:0]                        i_out_enable,
  input  wire logic [NUM_PAGES-1:0]                        i_rail_good_signal,
  input  wire logic [NUM_PAGES-1:0]                        i_ramp_done,
  input  wire logic [NUM_PAGES-1:0]                        i_share_group,
  output logic      [NUM_PAGES-1:0]                        o_rail_on,
  output logic      [NUM_PAGES-1:0]                        o_tune_enable,
  output logic      [NUM_PAGES-1:0][15:0]                  o_tune_gain,
  output logic      [NUM_PAGES-1:0][7:0]                   o_tune_residual,
  output logic      [NUM_PAGES-1:0]                        o_track_enable,
  output logic      [NUM_PAGES-1:0]                        o_track_half,
  output logic      [NUM_PAGES-1:0]                        o_track_limit_ref
);
  import rail_seq_pkg::*;

  localparam int PIN_W = 8 + 16 + 4 * NUM_PAGES;
  localparam int CNT_W = $clog2(TOFF_CYCLES + 1);

  if (NUM_PAGES < 1 || NUM_PAGES > (1 << PAGE_W) || TOFF_CYCLES < 1)
  begin : g_bad_cfg
    $error("rail_seq_dev: unsupported page count or delay");
  end

  logic [PIN_W-1:0]                  pin_meta_reg;
  logic [PIN_W-1:0]                  pin_sync_reg;
  logic [7:0]                        strap_s;
  logic [15:0]                       order_strap_s;
  logic [NUM_PAGES-1:0]              en_s, good_s, ramp_s, share_s, good_d_reg;
  logic [1:0]                        settle_reg;
  logic                              strap_done_reg;
  logic [15:0]                       strap_gain;
  logic [7:0]                        strap_res;
  logic [NUM_PAGES-1:0]              tune_user_reg, order_user_reg;
  logic [NUM_PAGES-1:0][15:0]        order_reg, order_eff;
  logic [NUM_PAGES-1:0][7:0]         track_reg;
  logic [NUM_PAGES-1:0]              pg_seen_reg, pd_seen_reg;
  logic [NUM_PAGES-1:0]              pend_good_reg, pend_down_reg;
  rail_state_t [NUM_PAGES-1:0]       state_reg;
  logic [NUM_PAGES-1:0][CNT_W-1:0]   toff_cnt_reg;
  logic                              wr_hit, res_bad, page_ok;
  logic [31:0]                       rd_word;

  // ==========================================================
  // pin synchroniser; the first stage feeds only the second
  always_ff @(posedge i_ref_clk or negedge i_rstn)
    if (!i_rstn)
    begin
      pin_meta_reg <= '0;
      pin_sync_reg <= '0;
    end
    else
    begin
      pin_meta_reg <= {i_tuning_strap_pin, i_order_strap, i_out_enable,
                       i_rail_good_signal, i_ramp_done, i_share_group};
      pin_sync_reg <= pin_meta_reg;
    end

  assign {strap_s, order_strap_s, en_s, good_s, ramp_s, share_s} = pin_sync_reg;

  // strap decode into tuning defaults
  assign strap_gain = STRAP_GAIN_BASE + 16'(strap_s * STRAP_GAIN_STEP);
  assign strap_res  = STRAP_RES_BASE + {3'b000, strap_s[4:0]};

  // strap is trusted only once it has crossed the synchroniser
  always_ff @(posedge i_ref_clk or negedge i_rstn)
    if (!i_rstn)
    begin
      settle_reg     <= 2'b00;
      strap_done_reg <= 1'b0;
    end
    else if (!strap_done_reg)
    begin
      settle_reg     <= settle_reg + 2'b01;
      strap_done_reg <= (settle_reg == 2'(STRAP_SETTLE));
    end

  // ==========================================================
  // command decode; answer one cycle after the request
  assign page_ok = (32'(bus.cmd_page) < 32'(NUM_PAGES));
  assign res_bad = bus.cmd_wdata[TUNE_RES_MSB:TUNE_RES_LSB] > TUNE_RES_MAX;
  assign wr_hit  = bus.cmd_valid & bus.cmd_write & page_ok;

  always_comb
  begin
    rd_word = 32'h0000_0000;
    case (bus.cmd_code)
      CODE_LOOP_TUNING: rd_word = {7'h00, o_tune_enable[bus.cmd_page],
                                   o_tune_residual[bus.cmd_page],
                                   o_tune_gain[bus.cmd_page]};
      CODE_RAIL_ORDER:  rd_word = {16'h0000, order_eff[bus.cmd_page]};
      CODE_VOLT_FOLLOW: rd_word = {24'h00_0000, track_reg[bus.cmd_page]};
      default:          rd_word = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge i_ref_clk or negedge i_rstn)
    if (!i_rstn)
    begin
      bus.rsp_valid <= 1'b0;
      bus.rsp_err   <= 1'b0;
      bus.rsp_rdata <= 32'h0000_0000;
    end
    else
    begin
      bus.rsp_valid <= bus.cmd_valid;
      bus.rsp_err   <= bus.cmd_valid & (!page_ok
                       || !(bus.cmd_code inside {CODE_LOOP_TUNING, CODE_RAIL_ORDER,
                                                 CODE_VOLT_FOLLOW})
                       || (bus.cmd_write && bus.cmd_code == CODE_LOOP_TUNING && res_bad));
      bus.rsp_rdata <= (bus.cmd_valid && !bus.cmd_write && page_ok) ? rd_word : 32'h0000_0000;
    end

  // ==========================================================
  // tuning word: strap at start, then derived, until software writes
  always_ff @(posedge i_ref_clk or negedge i_rstn)
    if (!i_rstn)
    begin
      tune_user_reg   <= '0;
      o_tune_enable   <= {NUM_PAGES{TUNE_EN_RESET}};
      o_tune_gain     <= '0;
      o_tune_residual <= '0;
    end
    else
      for (int p = 0; p < NUM_PAGES; p++)
      begin
        if (wr_hit && 32'(bus.cmd_page) == p && bus.cmd_code == CODE_LOOP_TUNING && !res_bad)
        begin
          // masked write keeps bits 31:25 at zero
          tune_user_reg[p]   <= 1'b1;
          o_tune_enable[p]   <= bus.cmd_wdata[TUNE_EN_BIT];
          o_tune_residual[p] <= bus.cmd_wdata[TUNE_RES_MSB:TUNE_RES_LSB];
          o_tune_gain[p]     <= bus.cmd_wdata[TUNE_GAIN_MSB:0];
        end
        else if (strap_done_reg && !tune_user_reg[p])
        begin
          // adapt from operating point; residual held inside its range
          o_tune_gain[p]     <= strap_gain + {6'h00, i_vout_cmd[p][15:6]};
          o_tune_residual[p] <= (strap_res + {5'h00, i_vin_meas[15:13]} > TUNE_RES_MAX)
                                ? TUNE_RES_MAX : strap_res + {5'h00, i_vin_meas[15:13]};
        end
        else if (!strap_done_reg)
        begin
          o_tune_gain[p]     <= strap_gain;
          o_tune_residual[p] <= strap_res;
        end
      end

  // ==========================================================
  // ordering and tracking words
  always_ff @(posedge i_ref_clk or negedge i_rstn)
    if (!i_rstn)
    begin
      order_user_reg <= '0;
      order_reg      <= {NUM_PAGES{ORDER_RESET}};
      track_reg      <= {NUM_PAGES{TRACK_RESET}};
    end
    else
      for (int p = 0; p < NUM_PAGES; p++)
        if (wr_hit && 32'(bus.cmd_page) == p)
        begin
          if (bus.cmd_code == CODE_RAIL_ORDER)
          begin
            order_user_reg[p] <= 1'b1;
            order_reg[p]      <= bus.cmd_wdata[15:0] & ORDER_MASK;
          end
          if (bus.cmd_code == CODE_VOLT_FOLLOW)
            track_reg[p] <= bus.cmd_wdata[7:0] & TRACK_MASK;
        end

  // strap ordering stands until software writes the word
  always_comb
    for (int p = 0; p < NUM_PAGES; p++)
      order_eff[p] = order_user_reg[p] ? order_reg[p] : (order_strap_s & ORDER_MASK);

  // tracking outputs; only the enable is blocked for multi-device sharing members
  always_ff @(posedge i_ref_clk or negedge i_rstn)
    if (!i_rstn)
    begin
      o_track_enable    <= '0;
      o_track_half      <= '0;
      o_track_limit_ref <= '0;
    end
    else
      for (int p = 0; p < NUM_PAGES; p++)
      begin
        o_track_enable[p]    <= track_reg[p][TRK_EN_BIT] & ~share_s[p];
        o_track_half[p]      <= track_reg[p][TRK_HALF_BIT];
        o_track_limit_ref[p] <= track_reg[p][TRK_LIMREF_BIT];
      end

  // ==========================================================
  // remembered events from the prequel and sequel rails
  always_ff @(posedge i_ref_clk or negedge i_rstn)
    if (!i_rstn)
    begin
      pg_seen_reg <= '0;
      pd_seen_reg <= '0;
    end
    else
      for (int p = 0; p < NUM_PAGES; p++)
        if (bus.dn_evt_valid)
        begin
          if (bus.dn_evt_rail == order_eff[p][PREQ_ID_LSB +: RAIL_ID_W])
            pg_seen_reg[p] <= (bus.dn_evt_kind == EVT_RAIL_GOOD);
          if (bus.dn_evt_rail == order_eff[p][SEQL_ID_LSB +: RAIL_ID_W])
            pd_seen_reg[p] <= (bus.dn_evt_kind == EVT_RAIL_DOWN);
        end

  // ==========================================================
  // per-page on/off sequence
  always_ff @(posedge i_ref_clk or negedge i_rstn)
    if (!i_rstn)
    begin
      state_reg    <= {NUM_PAGES{ST_OFF}};
      toff_cnt_reg <= '0;
    end
    else
      for (int p = 0; p < NUM_PAGES; p++)
        case (state_reg[p])
          ST_OFF:
            if (en_s[p] && strap_done_reg)
              state_reg[p] <= ST_WAIT_PREQ;
          ST_WAIT_PREQ:
            if (!en_s[p])
              state_reg[p] <= ST_OFF;
            else if (!order_eff[p][PREQ_EN_BIT] || pg_seen_reg[p])
              state_reg[p] <= ST_ON;
          ST_ON:
            if (!en_s[p])
              state_reg[p] <= ST_WAIT_SEQL;
          ST_WAIT_SEQL:
            if (en_s[p])
              state_reg[p] <= ST_ON;
            else if (!order_eff[p][SEQL_EN_BIT] || pd_seen_reg[p])
            begin
              state_reg[p]    <= ST_TOFF;
              toff_cnt_reg[p] <= CNT_W'(TOFF_CYCLES);
            end
          ST_TOFF:
            if (toff_cnt_reg[p] == CNT_W'(1))
              state_reg[p] <= ST_RAMP;
            else
              toff_cnt_reg[p] <= toff_cnt_reg[p] - CNT_W'(1);
          ST_RAMP:
            if (ramp_s[p])
              state_reg[p] <= ST_OFF;
          default:
            state_reg[p] <= ST_OFF;
        endcase

  // output stays on through the off delay, drops when the ramp starts
  always_ff @(posedge i_ref_clk or negedge i_rstn)
    if (!i_rstn)
      o_rail_on <= '0;
    else
      for (int p = 0; p < NUM_PAGES; p++)
        o_rail_on[p] <= (state_reg[p] == ST_ON) || (state_reg[p] == ST_WAIT_SEQL)
                        || (state_reg[p] == ST_TOFF);

  // ==========================================================
  // own events: good on rising rail_good while on, down at ramp end.
  // pending flags let two pages share the link; a new event beats the clear
  always_ff @(posedge i_ref_clk or negedge i_rstn)
    if (!i_rstn)
    begin
      good_d_reg       <= '0;
      pend_good_reg    <= '0;
      pend_down_reg    <= '0;
      bus.up_evt_valid <= 1'b0;
      bus.up_evt_kind  <= EVT_RAIL_GOOD;
      bus.up_evt_rail  <= '0;
    end
    else
    begin : send
      logic sent;
      sent             = 1'b0;
      good_d_reg       <= good_s;
      bus.up_evt_valid <= 1'b0;
      for (int p = 0; p < NUM_PAGES; p++)
      begin
        if (!sent && pend_good_reg[p])
        begin
          sent             = 1'b1;
          bus.up_evt_valid <= 1'b1;
          bus.up_evt_kind  <= EVT_RAIL_GOOD;
          bus.up_evt_rail  <= i_rail_id[p];
          pend_good_reg[p] <= 1'b0;
        end
        else if (!sent && pend_down_reg[p])
        begin
          sent             = 1'b1;
          bus.up_evt_valid <= 1'b1;
          bus.up_evt_kind  <= EVT_RAIL_DOWN;
          bus.up_evt_rail  <= i_rail_id[p];
          pend_down_reg[p] <= 1'b0;
        end
        if (good_s[p] && !good_d_reg[p] && state_reg[p] == ST_ON)
          pend_good_reg[p] <= 1'b1;
        if (state_reg[p] == ST_RAMP && ramp_s[p])
          pend_down_reg[p] <= 1'b1;
      end
    end

endmodule : rail_seq_dev

//--- test/rail_seq_asserts.sv
// concurrent checks on the command link; the event link is only covered
`timescale 1ns/1ps
module rail_seq_asserts
  import rail_seq_pkg::*;
(
  input wire logic        i_ref_clk,
  input wire logic        i_rstn,
  input wire logic        cmd_valid,
  input wire logic        cmd_write,
  input wire logic [7:0]  cmd_code,
  input wire logic [31:0] cmd_wdata,
  input wire logic        rsp_valid,
  input wire logic        rsp_err,
  input wire logic [31:0] rsp_rdata,
  input wire logic        up_evt_valid
);
  // ==========================================================
  // successful reads, split per command code
  logic rd;
  assign rd = rsp_valid && !rsp_err && !cmd_write;
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_rstn);
  // ==========================================================
  // answers and field layouts
  property p_answer;
    cmd_valid |=> rsp_valid ##1 !rsp_valid;
  endproperty
  a_answer: assert property (p_answer) else $error("no single answer");
  property p_tune_top;
    rd && cmd_code == CODE_LOOP_TUNING |-> rsp_rdata[31:25] == 7'h00;
  endproperty
  a_tune_top: assert property (p_tune_top) else $error("tuning top bits set");
  property p_tune_res;
    rd && cmd_code == CODE_LOOP_TUNING |-> !rsp_rdata[23];
  endproperty
  a_tune_res: assert property (p_tune_res) else $error("residual above range");
  property p_res_refuse;
    rsp_valid && cmd_write && cmd_code == CODE_LOOP_TUNING && cmd_wdata[23] |-> rsp_err;
  endproperty
  a_res_refuse: assert property (p_res_refuse) else $error("big residual taken");
  property p_order_hi;
    rd && cmd_code == CODE_RAIL_ORDER |-> rsp_rdata[14:13] == 2'h0;
  endproperty
  a_order_hi: assert property (p_order_hi) else $error("order high gap set");
  property p_order_lo;
    rd && cmd_code == CODE_RAIL_ORDER |-> rsp_rdata[6:5] == 2'h0 && rsp_rdata[31:16] == 16'h0000;
  endproperty
  a_order_lo: assert property (p_order_lo) else $error("order low gap set");
  property p_track;
    rd && cmd_code == CODE_VOLT_FOLLOW |-> (rsp_rdata & ~{24'h00_0000, TRACK_MASK}) == 32'h0000_0000;
  endproperty
  a_track: assert property (p_track) else $error("tracking gap set");
  property p_wr_quiet;
    rsp_valid && cmd_write |-> rsp_rdata == 32'h0000_0000;
  endproperty
  a_wr_quiet: assert property (p_wr_quiet) else $error("write returned data");
  // ==========================================================
  // main scenarios reached
  c_write: cover property (rsp_valid && cmd_write && !rsp_err);
  c_err: cover property (rsp_valid && rsp_err);
  c_evt: cover property (up_evt_valid);
endmodule : rail_seq_asserts

//--- test/rail_seq_tb_top.sv
// bench driving the controller end against the device end
`timescale 1ns/1ps
module rail_seq_tb_top;
  import rail_seq_pkg::*;
  // ==========================================================
  // stimulus and observed signals
  logic                ref_clk = 1'b0;
  logic                rstn = 1'b0;
  logic                req = 1'b0;
  logic                wr = 1'b0;
  logic [7:0]          code = 8'h00;
  logic                page = 1'b0;
  logic [31:0]         wdata = 32'h0000_0000;
  logic                evt_req = 1'b0;
  evt_kind_t           evt_kind = EVT_RAIL_GOOD;
  logic [4:0]          evt_rail = 5'h00;
  logic [1:0]          out_en = 2'b00, good = 2'b00, ramp_done = 2'b00, share = 2'b00;
  logic                rsp_valid, rsp_err;
  logic [31:0]         rdata;
  logic [1:0]          rail_on, tune_en, trk_en, trk_half, trk_lim;
  logic [1:0][15:0]    gain;
  logic [1:0][7:0]     res;
  logic                evt_v;
  evt_kind_t           evt_k;
  logic [4:0]          evt_r;
  logic [5:0]          last_evt = 6'h00;
  int                  num_errors = 0;
  int                  samples_checked = 0;
  rail_seq_if bus_if();
  rail_seq_ctl u_rail_seq_ctl (.i_ref_clk(ref_clk), .i_rstn(rstn), .bus(bus_if),
    .i_cmd_req(req), .i_cmd_write(wr), .i_cmd_code(code), .i_cmd_page(page),
    .i_cmd_wdata(wdata), .o_cmd_ready(), .o_rsp_valid(rsp_valid), .o_rsp_err(rsp_err),
    .o_rsp_rdata(rdata), .i_evt_req(evt_req), .i_evt_kind(evt_kind), .i_evt_rail(evt_rail),
    .o_evt_valid(evt_v), .o_evt_kind(evt_k), .o_evt_rail(evt_r));
  // last own event relayed back to the controller side
  always @(posedge ref_clk)
    if (evt_v === 1'b1)
      last_evt <= {evt_k, evt_r};
  // short turn-off count keeps the ramp-down walk brief
  // strap code 3 keeps gain and residual in the usual band
  // vout command stands at its steady value throughout
  rail_seq_dev #(.NUM_PAGES(2), .TOFF_CYCLES(4)) u_rail_seq_dev (.i_ref_clk(ref_clk),
    .i_rstn(rstn), .bus(bus_if), .i_tuning_strap_pin(8'h03), .i_order_strap(16'h0000),
    .i_vin_meas(16'h4000), .i_vout_cmd({16'h0100, 16'h0000}), .i_rail_id({5'h08, 5'h04}),
    .i_out_enable(out_en), .i_rail_good_signal(good), .i_ramp_done(ramp_done),
    .i_share_group(share), .o_rail_on(rail_on), .o_tune_enable(tune_en), .o_tune_gain(gain),
    .o_tune_residual(res), .o_track_enable(trk_en), .o_track_half(trk_half),
    .o_track_limit_ref(trk_lim));
  rail_seq_asserts u_rail_seq_asserts (.i_ref_clk(ref_clk), .i_rstn(rstn),
    .cmd_valid(bus_if.cmd_valid), .cmd_write(bus_if.cmd_write), .cmd_code(bus_if.cmd_code),
    .cmd_wdata(bus_if.cmd_wdata), .rsp_valid(bus_if.rsp_valid), .rsp_err(bus_if.rsp_err),
    .rsp_rdata(bus_if.rsp_rdata), .up_evt_valid(bus_if.up_evt_valid));
  // ==========================================================
  // clock and access tasks; inputs move 1 ns after the edge
  always #5 ref_clk = ~ref_clk;
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : tick
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e)
    begin
      num_errors++;
      $display("FAIL %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic acc(input logic w, input logic [7:0] c, input logic p, input logic [31:0] d,
                     input logic e);
    int n;
    n = 0;
    {req, wr, code, page, wdata} = {1'b1, w, c, p, d};
    tick(1);
    req = 1'b0;
    // bounded wait so a lost answer shows as a mismatch
    while (rsp_valid !== 1'b1 && n < 10)
    begin
      tick(1);
      n++;
    end
    chk("rsp_valid", 32'h0000_0001, {31'h0, rsp_valid});
    chk("rsp_err", {31'h0, e}, {31'h0, rsp_err});
  endtask : acc
  task automatic rd(input logic [7:0] c, input logic p, input logic [31:0] e);
    acc(1'b0, c, p, 32'h0000_0000, 1'b0);
    chk("rdata", e, rdata);
  endtask : rd
  task automatic ev(input evt_kind_t k, input logic [4:0] r);
    {evt_req, evt_kind, evt_rail} = {1'b1, k, r};
    tick(1);
    evt_req = 1'b0;
  endtask : ev
  task automatic results();
    if (num_errors == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : results
  // ==========================================================
  // main sequence
  initial
  begin
    tick(8);
    rstn = 1'b1;
    tick(12);
    rd(CODE_LOOP_TUNING, 1'b0, 32'h012D_007C);
    rd(CODE_LOOP_TUNING, 1'b1, 32'h012D_0080);
    rd(CODE_RAIL_ORDER, 1'b1, 32'h0000_0000);
    rd(CODE_VOLT_FOLLOW, 1'b1, 32'h0000_0000);
    acc(1'b1, CODE_LOOP_TUNING, 1'b0, 32'hFE7F_1234, 1'b0);
    acc(1'b1, CODE_LOOP_TUNING, 1'b0, 32'h0080_0005, 1'b1);
    rd(CODE_LOOP_TUNING, 1'b0, 32'h007F_1234);
    chk("gain", 32'h0000_1234, {16'h0000, gain[0]});
    chk("tune", 32'h0000_007F, {23'h0, tune_en[0], res[0]});
    acc(1'b1, CODE_VOLT_FOLLOW, 1'b0, 32'hFFFF_FFFF, 1'b0);
    rd(CODE_VOLT_FOLLOW, 1'b0, 32'h0000_0086);
    chk("track", 32'h0000_0007, {29'h0, trk_en[0], trk_half[0], trk_lim[0]});
    share = 2'b01;
    tick(6);
    chk("track_share", 32'h0000_0003, {29'h0, trk_en[0], trk_half[0], trk_lim[0]});
    acc(1'b1, CODE_RAIL_ORDER, 1'b0, 32'h0000_E3E5, 1'b0);
    rd(CODE_RAIL_ORDER, 1'b0, 32'h0000_8385);
    out_en = 2'b01;
    tick(10);
    chk("rail_on", 32'h0000_0000, {31'h0, rail_on[0]});
    ev(EVT_RAIL_GOOD, 5'h02);
    tick(6);
    chk("rail_on", 32'h0000_0000, {31'h0, rail_on[0]});
    ev(EVT_RAIL_GOOD, 5'h03);
    tick(6);
    chk("rail_on", 32'h0000_0001, {31'h0, rail_on[0]});
    good = 2'b01;
    out_en = 2'b00;
    tick(10);
    chk("rail_on", 32'h0000_0001, {31'h0, rail_on[0]});
    chk("evt_good", 32'h0000_0004, {26'h0, last_evt});
    ev(EVT_RAIL_DOWN, 5'h05);
    tick(3);
    chk("rail_on", 32'h0000_0001, {31'h0, rail_on[0]});
    ramp_done = 2'b01;
    tick(10);
    chk("rail_on", 32'h0000_0000, {31'h0, rail_on[0]});
    chk("evt_down", 32'h0000_0024, {26'h0, last_evt});
    results();
  end
  // watchdog: the whole sequence needs well under 1000 cycles
  initial
  begin
    #20000;
    num_errors++;
    results();
  end
endmodule : rail_seq_tb_top
